//--- include/dram_row_miss_retry_pkg.sv
// Constants, types and register map for the row-cache retry block.
// Assumes a single core clock and a sampled, free-standing link clock pin.
package dram_row_miss_retry_pkg;

    // ------------------------------------------------------------------
    // Register map (byte offsets on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [7:0] ROW_TIMING_OFS = 8'h00;
    localparam logic [7:0] SWAP_SELECT_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    // Field positions inside row_timing_register.
    localparam int PREP_POS = 0;
    localparam int SENSE_POS = 8;
    localparam int IMP_POS = 16;
    localparam int EXP_POS = 24;
    localparam int FIELD_W = 5;
    // Status bit positions.
    localparam int STAT_BUSY_POS = 8;
    localparam int STAT_IMP_POS = 9;

    // Reset values of the programmable counts and the swap select.
    localparam logic [31:0] ROW_TIMING_RST = 32'h040A_0701;
    localparam logic [8:0] SWAP_SELECT_RST = 9'h000;

    // ------------------------------------------------------------------
    // Fixed overheads, in link clock cycles
    // ------------------------------------------------------------------
    localparam logic [7:0] FETCH_OVH_CYC = 8'h07;
    localparam logic [7:0] REF_IDLE_OVH_CYC = 8'h0E;
    localparam logic [7:0] REF_REDUCED_OVH_CYC = 8'h14;
    localparam logic [7:0] REF_PAD_CYC = 8'h2A;
    localparam logic [7:0] PREP_OVH_CYC = 8'h06;
    localparam logic [7:0] SENSE_OVH_CYC = 8'h01;
    localparam logic [7:0] IMP_OVH_CYC = 8'h05;
    localparam logic [7:0] EXP_OVH_CYC = 8'h04;
    localparam logic [7:0] HOLD_OVH_CYC = 8'h01;
    localparam logic [7:0] REF_OVH_CYC =
        REF_IDLE_OVH_CYC + REF_REDUCED_OVH_CYC + REF_PAD_CYC;
    localparam logic [3:0] READ_HIT_CYC = 4'hA;
    localparam logic [3:0] WRITE_HIT_CYC = 4'h4;
    localparam logic [2:0] REF_ROWS = 3'h4;

    // ------------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------------
    localparam int NUM_BANKS = 2;
    localparam int BANK_BIT = 11;
    localparam int ROW_W = 16;
    localparam int SWAP_LO = 11;
    localparam int SWAP_HI = 20;
    localparam int SWAP_W = 9;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic strobe;
        logic write;
        logic close;
        logic refresh;
        logic [35:3] addr;
    } req_type;

    typedef struct packed {
        logic valid;
        logic okay;
    } ack_type;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_OVH = 3'b001,
        S_WB = 3'b010,
        S_PREP = 3'b011,
        S_SENSE = 3'b100,
        S_IMP = 3'b101,
        S_HOLD = 3'b110
    } state_type;

endpackage

//--- rtl/dram_row_miss_retry.sv
// Row-cache retry logic of the responding memory device.
// Assumes requests arrive as pin levels stable around a link clock edge.
`timescale 1ns/1ps
module dram_row_miss_retry (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Link pins.
    input wire logic i_link_clk,
    input wire dram_row_miss_retry_pkg::req_type i_req,
    output dram_row_miss_retry_pkg::ack_type o_ack,
    output logic o_data_start,
    output logic o_data_write,
    // Register port.
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata
);
    import dram_row_miss_retry_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Swap individual bits between the two nine-bit fields.
    function automatic logic [35:3] map_addr(input logic [35:3] a,
                                             input logic [8:0] sel);
        logic [35:3] m;
        m = a;
        for (int i = 0; i < SWAP_W; i++) begin
            if (sel[i]) begin
                m[SWAP_HI + i] = a[SWAP_LO + i];
                m[SWAP_LO + i] = a[SWAP_HI + i];
            end
        end
        return m;
    endfunction

    // Length of one phase: fixed overhead plus programmable count; S_OVH is fixed overhead alone.
    function automatic logic [7:0] phase_len(input state_type st,
                                             input logic is_ref,
                                             input logic [31:0] t);
        logic [7:0] p;
        logic [7:0] s;
        logic [7:0] i;
        logic [7:0] e;
        p = {3'h0, t[PREP_POS +: FIELD_W]};
        s = {3'h0, t[SENSE_POS +: FIELD_W]};
        i = {3'h0, t[IMP_POS +: FIELD_W]};
        e = {3'h0, t[EXP_POS +: FIELD_W]};
        case (st)
            S_OVH: phase_len = is_ref ? REF_OVH_CYC : FETCH_OVH_CYC;
            S_WB: phase_len = EXP_OVH_CYC + e;
            S_PREP: phase_len = PREP_OVH_CYC + p;
            S_SENSE: phase_len = SENSE_OVH_CYC + s;
            S_IMP: phase_len = IMP_OVH_CYC + i;
            S_HOLD: phase_len = HOLD_OVH_CYC + p;
            default: phase_len = 8'h01;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------

    // Two flops per pin; the third link clock flop only finds edges.
    logic lclk_s1_q;
    logic lclk_s2_q;
    logic lclk_s3_q;
    req_type req_s1_q;
    req_type req_s2_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            lclk_s1_q <= 1'b0;
            lclk_s2_q <= 1'b0;
            lclk_s3_q <= 1'b0;
            req_s1_q <= '0;
            req_s2_q <= '0;
        end else begin
            lclk_s1_q <= i_link_clk;
            lclk_s2_q <= lclk_s1_q;
            lclk_s3_q <= lclk_s2_q;
            req_s1_q <= i_req;
            req_s2_q <= req_s1_q;
        end
    end

    logic link_rise;
    logic take;
    logic [35:3] maddr;
    logic req_bank;
    logic [ROW_W-1:0] req_row;

    // Requests are taken once per link cycle, at its sampled rising edge.
    assign link_rise = lclk_s2_q & ~lclk_s3_q;
    assign take = link_rise & req_s2_q.strobe;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    logic [31:0] timing_q;
    logic [31:0] timing_d;
    logic [8:0] swap_q;
    logic [8:0] swap_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    state_type st_q;
    logic [5:0] imp_q;

    // Writes steer the timing and mapping; reads of holes return zero.
    always_comb begin
        timing_d = timing_q;
        swap_d = swap_q;
        rdata_d = 32'h0000_0000;
        if (i_reg_wr && i_reg_addr == ROW_TIMING_OFS) begin
            timing_d = i_reg_wdata & 32'h1F1F_1F1F;
        end
        if (i_reg_wr && i_reg_addr == SWAP_SELECT_OFS) begin
            swap_d = i_reg_wdata[8:0];
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                ROW_TIMING_OFS: rdata_d = timing_q;
                SWAP_SELECT_OFS: rdata_d = {23'h0, swap_q};
                STATUS_OFS: begin
                    rdata_d[2:0] = st_q;
                    rdata_d[STAT_BUSY_POS] = (st_q != S_IDLE);
                    rdata_d[STAT_IMP_POS] = (imp_q != 6'h00);
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            timing_q <= ROW_TIMING_RST;
            swap_q <= SWAP_SELECT_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            timing_q <= timing_d;
            swap_q <= swap_d;
            rdata_q <= rdata_d;
        end
    end

    assign maddr = map_addr(req_s2_q.addr, swap_q);
    assign req_bank = maddr[BANK_BIT];
    assign req_row = maddr[35:20];

    // ------------------------------------------------------------------
    // Row cache, retry sequencer and acknowledge
    // ------------------------------------------------------------------
    state_type st_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [2:0] round_q;
    logic [2:0] round_d;
    logic ref_q;
    logic ref_d;
    logic wb_q;
    logic wb_d;
    logic tgt_bank_q;
    logic tgt_bank_d;
    logic [ROW_W-1:0] tgt_row_q;
    logic [ROW_W-1:0] tgt_row_d;
    logic cur_bank_q;
    logic cur_bank_d;
    logic [5:0] imp_d;
    logic [NUM_BANKS-1:0] valid_q;
    logic [NUM_BANKS-1:0] valid_d;
    logic [NUM_BANKS-1:0] dirty_q;
    logic [NUM_BANKS-1:0] dirty_d;
    logic [ROW_W-1:0] row_q [NUM_BANKS];
    logic [ROW_W-1:0] row_d [NUM_BANKS];
    ack_type ack_q;
    ack_type ack_d;
    logic pend_q;
    logic pend_d;
    logic pend_wr_q;
    logic pend_wr_d;
    logic [3:0] lat_q;
    logic [3:0] lat_d;
    logic dstart_q;
    logic dstart_d;
    logic hit;

    assign hit = valid_q[req_bank] && (row_q[req_bank] == req_row);

    // All timing advances on link edges, since intervals are link cycles.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        round_d = round_q;
        ref_d = ref_q;
        wb_d = wb_q;
        tgt_bank_d = tgt_bank_q;
        tgt_row_d = tgt_row_q;
        cur_bank_d = cur_bank_q;
        imp_d = imp_q;
        valid_d = valid_q;
        dirty_d = dirty_q;
        row_d = row_q;
        ack_d = '0;
        pend_d = pend_q;
        pend_wr_d = pend_wr_q;
        lat_d = lat_q;
        dstart_d = 1'b0;
        if (link_rise) begin
            // The rewrite after a sense runs beside later transfers.
            if (imp_q != 6'h00) begin
                imp_d = imp_q - 6'h01;
            end
            // Data starts the hit latency after the okayed request.
            if (pend_q) begin
                if (lat_q == 4'h0) begin
                    dstart_d = 1'b1;
                    pend_d = 1'b0;
                end else begin
                    lat_d = lat_q - 4'h1;
                end
            end
        end
        if (take && st_q == S_IDLE && req_s2_q.refresh) begin
            // The refresh request itself is okayed, carrying no data.
            ack_d = '{valid: 1'b1, okay: 1'b1};
            ref_d = 1'b1;
            round_d = 3'h0;
            wb_d = dirty_q[cur_bank_q];
            st_d = S_OVH;
            // The taking edge is the first overhead cycle, so the device
            // is idle again exactly when the retry interval has passed.
            cnt_d = phase_len(S_OVH, 1'b1, timing_q) - 8'h02;
        end else if (take && st_q == S_IDLE && hit) begin
            ack_d = '{valid: 1'b1, okay: 1'b1};
            pend_d = 1'b1;
            pend_wr_d = req_s2_q.write;
            lat_d = (req_s2_q.write ? WRITE_HIT_CYC : READ_HIT_CYC) - 4'h1;
            cur_bank_d = req_bank;
            if (req_s2_q.write) begin
                dirty_d[req_bank] = 1'b1;
            end
        end else if (take && st_q == S_IDLE) begin
            // Miss: nack and fetch; a set close bit skips the write-back.
            ack_d = '{valid: 1'b1, okay: 1'b0};
            ref_d = 1'b0;
            tgt_bank_d = req_bank;
            tgt_row_d = req_row;
            wb_d = dirty_q[req_bank] && valid_q[req_bank]
                && !req_s2_q.close;
            st_d = S_OVH;
            // Counting the taking edge lets the retry edge itself be okayed.
            cnt_d = phase_len(S_OVH, 1'b0, timing_q) - 8'h02;
        end else if (take) begin
            // Busy: nothing from this request is kept.
            ack_d = '{valid: 1'b1, okay: 1'b0};
        end
        if (link_rise && st_q != S_IDLE) begin
            if (cnt_q != 8'h00) begin
                cnt_d = cnt_q - 8'h01;
            end else begin
                case (st_q)
                    S_OVH: begin
                        // A pending rewrite stretches the retry.
                        if (imp_q == 6'h00) begin
                            st_d = wb_q ? S_WB : S_PREP;
                        end
                    end
                    S_WB: begin
                        st_d = S_PREP;
                        if (ref_q) begin
                            dirty_d[cur_bank_q] = 1'b0;
                        end else begin
                            dirty_d[tgt_bank_q] = 1'b0;
                        end
                    end
                    S_PREP: st_d = S_SENSE;
                    S_SENSE: begin
                        if (!ref_q) begin
                            st_d = S_IDLE;
                            row_d[tgt_bank_q] = tgt_row_q;
                            valid_d[tgt_bank_q] = 1'b1;
                            dirty_d[tgt_bank_q] = 1'b0;
                            cur_bank_d = tgt_bank_q;
                            imp_d = 6'(phase_len(S_IMP, 1'b0, timing_q));
                        end else if (round_q < REF_ROWS) begin
                            st_d = S_IMP;
                        end else begin
                            st_d = S_HOLD;
                        end
                    end
                    S_IMP: begin
                        st_d = S_PREP;
                        round_d = round_q + 3'h1;
                    end
                    S_HOLD: begin
                        st_d = S_IDLE;
                        dirty_d[cur_bank_q] = 1'b0;
                    end
                    default: st_d = S_IDLE;
                endcase
                if (st_d != st_q && st_d != S_IDLE) begin
                    cnt_d = phase_len(st_d, ref_q, timing_q) - 8'h01;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_q <= S_IDLE;
            cnt_q <= 8'h00;
            round_q <= 3'h0;
            ref_q <= 1'b0;
            wb_q <= 1'b0;
            tgt_bank_q <= 1'b0;
            tgt_row_q <= '0;
            cur_bank_q <= 1'b0;
            imp_q <= 6'h00;
            valid_q <= '0;
            dirty_q <= '0;
            row_q <= '{default: '0};
            ack_q <= '0;
            pend_q <= 1'b0;
            pend_wr_q <= 1'b0;
            lat_q <= 4'h0;
            dstart_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            round_q <= round_d;
            ref_q <= ref_d;
            wb_q <= wb_d;
            tgt_bank_q <= tgt_bank_d;
            tgt_row_q <= tgt_row_d;
            cur_bank_q <= cur_bank_d;
            imp_q <= imp_d;
            valid_q <= valid_d;
            dirty_q <= dirty_d;
            row_q <= row_d;
            ack_q <= ack_d;
            pend_q <= pend_d;
            pend_wr_q <= pend_wr_d;
            lat_q <= lat_d;
            dstart_q <= dstart_d;
        end
    end

    assign o_ack = ack_q;
    assign o_data_start = dstart_q;
    assign o_data_write = pend_wr_q;
    assign o_reg_rdata = rdata_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    // A nack never arms a data packet.
    nack_no_data_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (ack_d.valid && !ack_d.okay && !pend_q) |=> !pend_q)
        else $error("data armed by a nacked request");

    // Requests seen while busy are nacked on the next cycle.
    busy_nack_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (take && st_q != S_IDLE) |=> (o_ack.valid && !o_ack.okay))
        else $error("busy request not nacked");

    // A miss is nacked and enters the fetch overhead of seven cycles.
    miss_fetch_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (take && st_q == S_IDLE && !req_s2_q.refresh && !hit)
        |=> (st_q == S_OVH && cnt_q == FETCH_OVH_CYC - 8'h02 && !o_ack.okay))
        else $error("miss did not start a fetch");

    // The end of a fetch loads the row register and sets valid.
    fetch_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (link_rise && st_q == S_SENSE && cnt_q == 8'h00 && !ref_q)
        |=> (valid_q[tgt_bank_q] && row_q[tgt_bank_q] == tgt_row_q
             && st_q == S_IDLE))
        else $error("fetch did not load the row");

    // An okayed write marks its bank dirty.
    write_dirty_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (take && st_q == S_IDLE && hit && req_s2_q.write
         && !req_s2_q.refresh) |=> dirty_q[$past(req_bank)])
        else $error("write hit left bank clean");

    // Write-back follows the overhead exactly when it was needed.
    wb_order_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (link_rise && st_q == S_OVH && cnt_q == 8'h00 && imp_q == 6'h00)
        |=> (st_q == (wb_q ? S_WB : S_PREP)))
        else $error("wrong phase after overhead");

    // A read hit okay loads the read hit latency, less one, into the latency count.
    hit_latency_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (o_ack.valid && o_ack.okay && pend_q && !o_data_write
         && st_q == S_IDLE)
        |-> (lat_q == READ_HIT_CYC - 4'h1))
        else $error("read hit latency not loaded");

    // The refresh ends by clearing the current row dirty flag.
    refresh_clear_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (link_rise && st_q == S_HOLD && cnt_q == 8'h00)
        |=> (!dirty_q[cur_bank_q] && st_q == S_IDLE))
        else $error("refresh left the row dirty");

    // Untouched address bits pass and full select swaps both fields.
    map_pass_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (maddr[35:29] == req_s2_q.addr[35:29]
         && maddr[10:3] == req_s2_q.addr[10:3]))
        else $error("pass-through address bits altered");

    swap_full_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (swap_q == 9'h1FF) |-> (maddr[28:20] == req_s2_q.addr[19:11]
                                && maddr[19:11] == req_s2_q.addr[28:20]))
        else $error("full swap did not exchange fields");

endmodule

//--- dv/link_host.sv
// Channel initiator model: link clock and whole requests.
// Assumes the device answers each request on the core clock.
`timescale 1ns/1ps
module link_host (
    // Core clock.
    input wire logic i_ref_clk,
    // Channel pins.
    input wire dram_row_miss_retry_pkg::ack_type i_ack,
    output logic o_link_clk,
    output dram_row_miss_retry_pkg::req_type o_req,
    output int o_edges
);
    import dram_row_miss_retry_pkg::*;
    int cnt = 0;
    assign o_edges = cnt;
    // The channel clock runs free; its rising edges are counted.
    initial begin
        o_link_clk = 1'b0;
        o_req = '0;
        forever #80 o_link_clk = ~o_link_clk;
    end
    always @(posedge o_link_clk) cnt <= cnt + 1;
    // Requests start mid link cycle, clear of the device's sync delay.
    task automatic send(input int at, input logic [2:0] kind,
            input logic [35:3] adr, output logic ok, output int e);
        int n;
        n = 0;
        do @(negedge o_link_clk); while (cnt < at - 1);
        @(posedge i_ref_clk);
        o_req <= {1'b1, kind, adr};
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (i_ack.valid !== 1'b1 && n < 60);
        ok = i_ack.okay;
        e = (n < 60) ? cnt : -1;
        // A released address shows its inverse, never the stale value.
        o_req <= {4'h0, ~adr};
    endtask
endmodule

//--- dv/tb.sv
// Self-checking bench for the row-cache retry block.
// Assumes link_host drives the channel side.
`timescale 1ns/1ps
module tb;
    import dram_row_miss_retry_pkg::*;
    logic clk, rst_n, link_clk, data_start, data_write, reg_wr, reg_rd;
    req_type req;
    ack_type ack;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [35:3] a;
    logic [35:3] hits [3];
    int edges, e, fails = 0, compares = 0, starts = 0;

    // ------------
    // Bench parts
    // ------------
    dram_row_miss_retry DUT (
        .i_ref_clk(clk),
        .i_rst_n(rst_n),
        .i_link_clk(link_clk),
        .i_req(req),
        .o_ack(ack),
        .o_data_start(data_start),
        .o_data_write(data_write),
        .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata),
        .i_reg_wr(reg_wr),
        .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata)
    );
    link_host host (
        .i_ref_clk(clk),
        .i_ack(ack),
        .o_link_clk(link_clk),
        .o_req(req),
        .o_edges(edges)
    );
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Packet starts are counted so a nacked request shows no data.
    always @(posedge clk) if (data_start === 1'b1) starts <= starts + 1;
    task automatic check(input string what, input logic [35:0] seen,
            input logic [35:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("Compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One register cycle; a read word stands only in the next cycle.
    task automatic reg_op(input logic wr, input logic [7:0] adr,
            input logic [31:0] d);
        @(posedge clk);
        reg_addr <= adr;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= ~wr;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clk);
        rd = reg_rdata;
    endtask
    task automatic req_at(input int at, input logic [2:0] k,
            input logic [35:3] adr, input logic exp_ok);
        logic ok;
        host.send(at, k, adr, ok, e);
        check("okay", ok, exp_ok);
        check("edge", e, at);
        if (e < 0) test_done();
    endtask
    // Opening request, last nacked slot of the gap, first served slot.
    task automatic retry(input logic [2:0] k, input int gap,
            input logic first_ok);
        int e1, s;
        req_at(edges + 2, k, a, first_ok);
        e1 = e;
        s = starts;
        reg_op(1'b0, STATUS_OFS, 32'h0);
        check("busy", rd[STAT_BUSY_POS], 1'b1);
        req_at(e1 + gap - 1, k & 3'b110, a, 1'b0);
        check("idle", starts, s);
        req_at(e1 + gap, k & 3'b110, a, 1'b1);
        e = e1;
    endtask
    // Waits for the data packet and checks its delay from edge e.
    task automatic data_check(input int total, input logic w);
        int n;
        n = 0;
        while (data_start !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        check("latency", edges - e, total);
        check("direction", data_write, w);
        if (n == 500) test_done();
    endtask
    initial begin
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        hits = '{33'h1 << 18, 33'h1, 33'h1 << 7};
        void'($urandom(48));
        a = 33'({$urandom, $urandom});
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        reg_op(1'b0, ROW_TIMING_OFS, 32'h0);
        check("timing", rd, ROW_TIMING_RST);
        reg_op(1'b0, 8'h0C, 32'h0);
        check("unmapped", rd, 32'h0);
        // Cold miss, then a write hit to the same row.
        retry(3'b000, 22, 1'b0);
        data_check(32, 1'b0);
        req_at(edges + 2, 3'b100, a ^ 33'h1, 1'b1);
        data_check(4, 1'b1);
        // Dirty miss, then close skips the dirty row's write-back.
        repeat (20) @(posedge link_clk);
        a[30] = ~a[30];
        retry(3'b100, 30, 1'b0);
        data_check(34, 1'b1);
        repeat (20) @(posedge link_clk);
        a[31] = ~a[31];
        retry(3'b010, 22, 1'b0);
        // Refresh on a clean then a dirty row; the row stays cached.
        repeat (20) @(posedge link_clk);
        retry(3'b001, 213, 1'b1);
        req_at(edges + 2, 3'b100, a, 1'b1);
        repeat (20) @(posedge link_clk);
        retry(3'b001, 221, 1'b1);
        // Refresh left the row clean, so a miss takes the clean gap.
        repeat (20) @(posedge link_clk);
        a[32] = ~a[32];
        retry(3'b000, 22, 1'b0);
        // Full swap: raw bits 21, 3 and 10 fall outside the row, 12 joins it.
        reg_op(1'b1, SWAP_SELECT_OFS, 32'h0000_01FF);
        reg_op(1'b0, SWAP_SELECT_OFS, 32'h0);
        check("swap", rd, 32'h0000_01FF);
        repeat (20) @(posedge link_clk);
        a = 33'({$urandom, $urandom});
        retry(3'b000, 22, 1'b0);
        foreach (hits[i]) begin
            req_at(edges + 2, 3'b000, a ^ hits[i], 1'b1);
            data_check(10, 1'b0);
        end
        req_at(edges + 2, 3'b000, a ^ (33'h1 << 9), 1'b0);
        test_done();
    end
endmodule
